// ==== frtc_pkg.sv ====
// frtc_pkg: register map, field layout and reset values of the
// free-running timer with two edge-capture channels.
// assumes a 32-bit APB slave; each register one aligned word.
package frtc_pkg;
   // printed offsets are not multiples of four: they are indices
   localparam logic [7:0] IDX_TMR_LO     = 8'h20;
   localparam logic [7:0] IDX_TMR_HI     = 8'h21;
   localparam logic [7:0] IDX_CAP0_RISE  = 8'h22;
   localparam logic [7:0] IDX_CAP1_RISE  = 8'h23;
   localparam logic [7:0] IDX_CAP0_FALL  = 8'h24;
   localparam logic [7:0] IDX_CAP1_FALL  = 8'h25;
   localparam logic [7:0] IDX_IRQ_EN     = 8'h26;
   localparam logic [7:0] IDX_CFG        = 8'h2a;
   localparam int         ADDR_W         = 10;
   // configuration fields
   localparam int         CFG_HOLD_BIT   = 7;
   localparam int         CFG_SHIFT_HI   = 6;
   localparam int         CFG_SHIFT_LO   = 4;
   localparam int         CFG_WIDE_BIT   = 3;
   localparam logic [7:0] CFG_WMASK      = 8'hf8;
   localparam logic [7:0] CFG_RST        = 8'h00;
   localparam logic [15:0] TMR_RST       = 16'h0000;
   localparam logic [7:0] CAP_RST        = 8'h00;
   localparam logic [3:0] IRQ_EN_RST     = 4'h0;
   // wrap is serviced at priority 17, vector 0044h
   localparam int         WRAP_PRIORITY  = 17;
   localparam logic [15:0] WRAP_VECTOR   = 16'h0044;
   // timer tick divider default: one tick per clock
   localparam int         TICK_DIV_RST   = 1;
endpackage

// ==== frtc_timer_capture.sv ====
// frtc_timer_capture: 16-bit free-running timer, two 8-bit capture
// channels (rise/fall each), optional joined 16-bit capture, APB regs.
// assumes cap_in pins are asynchronous to clk; one clock domain.
//
// Notes on behaviour
// R1: software reads timer low byte first; high byte comes from a snapshot.
// R2: software writes low byte first; whole count commits on high write.
// R3: two channels, each with rising and falling capture registers.
// R4: in joined mode channel 1 registers hold the upper capture byte.
// R5: each capture register has its own interrupt request enable.
// R6: one first-edge-hold bit governs all four capture registers.
// R7: hold clear: every qualifying edge overwrites the capture register.
// R8: hold set: first edge kept until register is read, re-arming it.
// R9: shift field n captures timer bits n+7 down to n.
// R10: wide bit makes channel 1 extend channel 0 to sixteen bits.
// R11: configuration bits 2..0 read zero; register resets to zero.
// R12: count rollover raises a distinct wrap request.
// R13: count advances once per tick, wrapping from all ones to zero.
// R14: joined mode: reading the upper-byte register re-arms the pair.
`timescale 1ns/100ps
module frtc_timer_capture #(
   parameter int TICK_DIV = frtc_pkg::TICK_DIV_RST
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // capture edge inputs
   input  wire logic [1:0]  cap_in,
   // interrupt requests
   output logic [3:0]       cap_irq,
   output logic             wrap_irq
);
   logic [15:0] count_reg;
   logic [7:0]  lo_stage_reg;
   logic [7:0]  hi_snap_reg;
   logic [7:0]  cfg_reg;
   logic [3:0]  irq_en_reg;
   logic [7:0]  cap_reg [4];
   logic [3:0]  full_reg;
   logic [1:0]  sync1_reg;
   logic [1:0]  sync2_reg;
   logic [1:0]  prev_reg;
   logic [15:0] tick_cnt_reg;
   logic        tick;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [7:0]  idx;
   logic        hold;
   logic        wide;
   logic [2:0]  shift;
   logic [3:0]  edge_ev;
   logic [3:0]  load;
   logic [3:0]  rd_cap;
   logic [7:0]  slice;
   logic [7:0]  rdata;

   // cap index: 0 ch0 rise, 1 ch1 rise, 2 ch0 fall, 3 ch1 fall
   function automatic logic [7:0] cap_idx(input logic [1:0] i);
      unique case (i)
         2'd0: cap_idx = frtc_pkg::IDX_CAP0_RISE;
         2'd1: cap_idx = frtc_pkg::IDX_CAP1_RISE;
         2'd2: cap_idx = frtc_pkg::IDX_CAP0_FALL;
         default: cap_idx = frtc_pkg::IDX_CAP1_FALL;
      endcase
   endfunction

   assign idx     = paddr[9:2];
   assign addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                    (idx == frtc_pkg::IDX_TMR_LO ||
                     idx == frtc_pkg::IDX_TMR_HI ||
                     idx == frtc_pkg::IDX_CAP0_RISE ||
                     idx == frtc_pkg::IDX_CAP1_RISE ||
                     idx == frtc_pkg::IDX_CAP0_FALL ||
                     idx == frtc_pkg::IDX_CAP1_FALL ||
                     idx == frtc_pkg::IDX_IRQ_EN ||
                     idx == frtc_pkg::IDX_CFG);
   // zero-wait slave; unmapped addresses answer with pslverr
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en   = psel && penable && pwrite && addr_ok;
   // reads act at setup, where prdata loads: data, snapshot, re-arm agree
   assign rd_en   = psel && !penable && !pwrite && addr_ok;

   assign hold  = cfg_reg[frtc_pkg::CFG_HOLD_BIT];
   assign wide  = cfg_reg[frtc_pkg::CFG_WIDE_BIT];
   assign shift = cfg_reg[frtc_pkg::CFG_SHIFT_HI:frtc_pkg::CFG_SHIFT_LO];

   // timer tick enable from divider
   always_ff @(posedge clk) begin
      if (!resetn || tick)
         tick_cnt_reg <= 16'h0000;
      else
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
   end
   assign tick = (tick_cnt_reg == 16'(TICK_DIV - 1));

   // free-running count and low-byte staging
   always_ff @(posedge clk) begin
      if (!resetn) begin
         count_reg    <= frtc_pkg::TMR_RST;
         lo_stage_reg <= 8'h00;
      end else if (wr_en && idx == frtc_pkg::IDX_TMR_HI) begin
         count_reg    <= {pwdata[7:0], lo_stage_reg}; // R2
      end else begin
         if (wr_en && idx == frtc_pkg::IDX_TMR_LO)
            lo_stage_reg <= pwdata[7:0]; // R2
         if (tick)
            count_reg <= count_reg + 16'h0001; // R13
      end
   end

   // wrap request, one-cycle pulse
   always_ff @(posedge clk) begin
      if (!resetn)
         wrap_irq <= 1'b0;
      else
         wrap_irq <= tick && (count_reg == 16'hffff) &&
                     !(wr_en && idx == frtc_pkg::IDX_TMR_HI); // R12
   end

   // high byte snapshot taken on low-byte read
   always_ff @(posedge clk) begin
      if (!resetn)
         hi_snap_reg <= 8'h00;
      else if (rd_en && idx == frtc_pkg::IDX_TMR_LO)
         hi_snap_reg <= count_reg[15:8]; // R1
   end

   // configuration and enables
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_reg    <= frtc_pkg::CFG_RST; // R11
         irq_en_reg <= frtc_pkg::IRQ_EN_RST;
      end else if (wr_en && idx == frtc_pkg::IDX_CFG) begin
         cfg_reg    <= pwdata[7:0] & frtc_pkg::CFG_WMASK; // R11
      end else if (wr_en && idx == frtc_pkg::IDX_IRQ_EN) begin
         irq_en_reg <= pwdata[3:0]; // R5
      end
   end

   // edge inputs: two-stage synchroniser then edge detect
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_reg <= 2'b00;
         sync2_reg <= 2'b00;
         prev_reg  <= 2'b00;
      end else begin
         sync1_reg <= cap_in;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // joined mode: channel 1 edges ignored, channel 0 drives both bytes
   always_comb begin
      edge_ev[0] = sync2_reg[0] && !prev_reg[0];
      edge_ev[2] = !sync2_reg[0] && prev_reg[0];
      edge_ev[1] = wide ? edge_ev[0]
                        : (sync2_reg[1] && !prev_reg[1]); // R10
      edge_ev[3] = wide ? edge_ev[2]
                        : (!sync2_reg[1] && prev_reg[1]); // R10
   end

   assign slice = 8'(count_reg >> shift); // R9

   // reads that re-arm; joined pair re-arms on the upper-byte read
   always_comb begin
      for (int i = 0; i < 4; i++)
         rd_cap[i] = rd_en && idx == cap_idx(2'(i));
      if (wide) begin
         rd_cap[0] = rd_cap[1]; // R14
         rd_cap[2] = rd_cap[3]; // R14
      end
   end

   // one hold bit for all four; each register gates on its own full bit
   always_comb begin
      for (int i = 0; i < 4; i++)
         load[i] = edge_ev[i] && !(hold && full_reg[i]); // R6 R7 R8
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            cap_reg[i] <= frtc_pkg::CAP_RST;
         end
         full_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (load[i]) begin
               if (wide)
                  cap_reg[i] <= (i % 2 == 0) ? count_reg[7:0]
                                             : count_reg[15:8]; // R4
               else
                  cap_reg[i] <= slice; // R3 R9
            end
            // a load in the read cycle wins: the new edge stays held
            if (load[i])
               full_reg[i] <= 1'b1; // R8
            else if (rd_cap[i])
               full_reg[i] <= 1'b0; // R8
         end
      end
   end

   // capture requests, one-cycle pulse per enabled register
   always_ff @(posedge clk) begin
      if (!resetn)
         cap_irq <= 4'h0;
      else
         cap_irq <= load & irq_en_reg; // R5
   end

   always_comb begin
      rdata = 8'h00;
      if (idx == frtc_pkg::IDX_TMR_LO)
         rdata = count_reg[7:0];
      else if (idx == frtc_pkg::IDX_TMR_HI)
         rdata = hi_snap_reg; // R1
      else if (idx == frtc_pkg::IDX_IRQ_EN)
         rdata = {4'h0, irq_en_reg};
      else if (idx == frtc_pkg::IDX_CFG)
         rdata = cfg_reg;
      else
         for (int i = 0; i < 4; i++)
            if (idx == cap_idx(2'(i)))
               rdata = cap_reg[i];
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {24'h000000, addr_ok ? rdata : 8'h00};
   end

   // assertions
   timer_wrap_a: assert property (@(posedge clk) disable iff (!resetn) // R12
      tick && count_reg == 16'hffff && !(wr_en && idx == 8'h21)
      |=> wrap_irq && count_reg == 16'h0000)
      else $error("wrap not flagged");
   timer_step_a: assert property (@(posedge clk) disable iff (!resetn) // R13
      tick && !wr_en |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("timer did not advance");
   high_commit_a: assert property (@(posedge clk) disable iff (!resetn) // R2
      wr_en && idx == 8'h21 |=>
      count_reg == {$past(pwdata[7:0]), $past(lo_stage_reg)})
      else $error("high write did not commit");
   cfg_reserved_a: assert property (@(posedge clk) disable iff (!resetn) // R11
      cfg_reg[2:0] == 3'b000)
      else $error("reserved cfg bits set");
   hold_keep_a: assert property (@(posedge clk) disable iff (!resetn) // R8
      hold && full_reg[0] && !rd_cap[0] |=> cap_reg[0] == $past(cap_reg[0]))
      else $error("held capture overwritten");
   latest_edge_a: assert property (@(posedge clk) disable iff (!resetn) // R7
      !hold && edge_ev[0] && !wide |=> cap_reg[0] == $past(slice))
      else $error("edge not captured");
   wide_pair_a: assert property (@(posedge clk) disable iff (!resetn) // R4
      wide && load[1] |=> cap_reg[1] == $past(count_reg[15:8]))
      else $error("upper byte wrong");
   cap_irq_a: assert property (@(posedge clk) disable iff (!resetn) // R5
      load[2] && irq_en_reg[2] |=> cap_irq[2])
      else $error("capture request missing");
   hi_read_a: assert property (@(posedge clk) disable iff (!resetn) // R1
      rd_en && idx == 8'h21 |=> prdata[7:0] == $past(hi_snap_reg))
      else $error("high byte not snapshot");
   // joined pair: both bytes from one edge, re-armed together
   sequence wide_rise_s;
      wide && load[0];
   endsequence
   sequence pair_read_s;
      wide && rd_cap[1] && !load[0] && !load[1];
   endsequence
   wide_low_a: assert property (@(posedge clk) disable iff (!resetn) // R4
      wide_rise_s |=> cap_reg[0] == $past(count_reg[7:0]))
      else $error("lower byte wrong");
   pair_rearm_a: assert property (@(posedge clk) disable iff (!resetn) // R14
      pair_read_s |=> !full_reg[0] && !full_reg[1])
      else $error("joined pair not re-armed");
   slice_top_a: assert property (@(posedge clk) disable iff (!resetn) // R9
      !wide && load[2] && shift == 3'd7 |=>
      cap_reg[2] == $past(count_reg[14:7]))
      else $error("capture slice wrong");
   irq_gate_a: assert property (@(posedge clk) disable iff (!resetn) // R5
      !irq_en_reg[1] |=> !cap_irq[1])
      else $error("disabled capture request raised");
   wrap_once_a: assert property (@(posedge clk) disable iff (!resetn) // R12
      wrap_irq |=> !wrap_irq)
      else $error("wrap request longer than one cycle");
   ch1_ignore_a: assert property (@(posedge clk) disable iff (!resetn) // R10
      wide && !edge_ev[0] && !edge_ev[2] |-> !load[1] && !load[3])
      else $error("channel 1 captured in joined mode");
endmodule

// ==== frtc_edge_src.sv ====
// frtc_edge_src: drives the two capture edge pins for the bench.
// assumes pulse() is entered just after a rising clock edge.
`timescale 1ns/100ps
module frtc_edge_src (
   // clock
   input  wire logic       clk,
   // capture pins
   output logic      [1:0] cap_in
);
   initial cap_in = 2'b00;
   // six clocks each way: the synchroniser must see both edges
   task automatic pulse(input logic [1:0] m);
      cap_in <= m;
      repeat (6) @(posedge clk);
      cap_in <= 2'b00;
      repeat (6) @(posedge clk);
   endtask
endmodule

// ==== free_running_timer_capture_tb.sv ====
// free_running_timer_capture_tb: apb register tests of the timer
// and capture block, with an edge source on the capture pins.
// assumes one clock; a slow tick keeps captured values near a write.
`timescale 1ns/100ps
module free_running_timer_capture_tb;
   localparam int TD = 4096;
   localparam logic [7:0] CI [4] = '{frtc_pkg::IDX_CAP0_RISE,
      frtc_pkg::IDX_CAP1_RISE, frtc_pkg::IDX_CAP0_FALL,
      frtc_pkg::IDX_CAP1_FALL};
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  cap_in;
   logic [3:0]  cap_irq;
   logic        wrap_irq;
   logic [7:0]  rv;
   logic        ev;
   logic [15:0] tv;
   int          icnt [4] = '{0, 0, 0, 0};
   int          wcnt = 0;
   int          error_cnt = 0;
   int          total_checks = 0;

   always #20 clk = ~clk;

   frtc_timer_capture #(.TICK_DIV(TD)) uut (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cap_in(cap_in), .cap_irq(cap_irq),
      .wrap_irq(wrap_irq));
   frtc_edge_src src (.clk(clk), .cap_in(cap_in));

   always @(posedge clk) begin
      for (int k = 0; k < 4; k++)
         if (cap_irq[k] === 1'b1) icnt[k]++;
      if (wrap_irq === 1'b1) wcnt++;
   end

   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic chk2(string n, logic [7:0] e0, e1, g);
      total_checks++;
      if (g !== e0 && g !== e1) begin
         $display("CHECK FAILED %s exp %h or %h got %h", n, e0, e1, g);
         error_cnt++;
      end
   endtask
   // always leaves an edge before raising psel again
   // upper address and data bits vary so that refusals get exercised
   task automatic apb(logic w, logic [7:0] i, logic [7:0] d = 8'h00,
                      logic [1:0] hi = 2'b00, logic [1:0] lo = 2'b00);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {hi, i, lo};
      pwdata <= {~d, ~d, ~d, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rv = prdata[7:0];
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic set_t(logic [15:0] v);
      apb(1'b1, frtc_pkg::IDX_TMR_LO, v[7:0]);
      apb(1'b1, frtc_pkg::IDX_TMR_HI, v[15:8]);
   endtask
   task automatic get_t();
      apb(1'b0, frtc_pkg::IDX_TMR_LO);
      tv[7:0] = rv;
      apb(1'b0, frtc_pkg::IDX_TMR_HI);
      tv[15:8] = rv;
   endtask
   function automatic logic [7:0] sl(logic [15:0] v, int n);
      return 8'(v >> n);
   endfunction
   // a tick may land between timer write and edge: allow v or v+1
   task automatic rd4(logic [15:0] v, int n);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, CI[k]);
         chk2("capture", sl(v, n), sl(v + 16'h1, n), rv);
      end
   endtask
   task automatic cfg_t(logic [7:0] c, logic [15:0] v, logic [1:0] m);
      apb(1'b1, frtc_pkg::IDX_CFG, c);
      set_t(v);
      src.pulse(m);
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, frtc_pkg::IDX_CFG);
      chk("cfg reset", 8'h00, rv);
      apb(1'b1, frtc_pkg::IDX_CFG, 8'hff);
      apb(1'b0, frtc_pkg::IDX_CFG);
      chk("cfg reserved", 8'hf8, rv);
      apb(1'b0, 8'h27);
      chk("unmapped", 8'h01, {7'h0, ev});
      chk("unmapped data", 8'h00, rv);
      // misaligned and out-of-range accesses are refused
      apb(1'b1, frtc_pkg::IDX_CFG, 8'h00, 2'b00, 2'b01);
      chk("misaligned", 8'h01, {7'h0, ev});
      apb(1'b0, frtc_pkg::IDX_CFG, 8'h00, 2'b01);
      chk("out of range", 8'h01, {7'h0, ev});
      chk("out of range data", 8'h00, rv);
      apb(1'b0, frtc_pkg::IDX_CFG);
      chk("cfg kept", 8'hf8, rv);
      // second reset in mid-run: configuration back to zero
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, frtc_pkg::IDX_CFG);
      chk("cfg second reset", 8'h00, rv);
      for (int n = 0; n < 8; n++) begin
         cfg_t(8'(n << 4), 16'ha5c3, 2'b11);
         rd4(16'ha5c3, n);
      end
      cfg_t(8'h00, 16'h0033, 2'b11);
      set_t(16'h0044);
      src.pulse(2'b11);
      rd4(16'h0044, 0);
      cfg_t(8'h80, 16'h0011, 2'b11);
      set_t(16'h0022);
      src.pulse(2'b11);
      rd4(16'h0011, 0);
      src.pulse(2'b11);
      rd4(16'h0022, 0);
      cfg_t(8'h08, 16'h5a3c, 2'b01);
      apb(1'b0, frtc_pkg::IDX_CAP0_RISE);
      chk2("wide lo", 8'h3c, 8'h3d, rv);
      set_t(16'h0f0f);
      src.pulse(2'b10);
      apb(1'b0, frtc_pkg::IDX_CAP1_RISE);
      chk("wide hi", 8'h5a, rv);
      cfg_t(8'h88, 16'h1234, 2'b01);
      set_t(16'h5678);
      src.pulse(2'b01);
      apb(1'b0, frtc_pkg::IDX_CAP0_RISE);
      chk2("pair lo", 8'h34, 8'h35, rv);
      apb(1'b0, frtc_pkg::IDX_CAP1_RISE);
      chk("pair hi", 8'h12, rv);
      src.pulse(2'b01);
      apb(1'b0, frtc_pkg::IDX_CAP0_RISE);
      chk2("rearm lo", 8'h78, 8'h79, rv);
      apb(1'b0, frtc_pkg::IDX_CAP1_RISE);
      chk("rearm hi", 8'h56, rv);
      apb(1'b1, frtc_pkg::IDX_IRQ_EN, 8'h05);
      cfg_t(8'h00, 16'h0100, 2'b11);
      for (int k = 0; k < 4; k++)
         chk("irq", 8'(k % 2 == 0), 8'(icnt[k]));
      set_t(16'hffff);
      repeat (2 * TD + 20) @(posedge clk);
      chk("wrap", 8'h01, 8'(wcnt));
      get_t();
      chk("rolled", 8'h00, tv[15:8]);
      // two or three ticks since the write, depending on divider phase
      chk2("rolled lo", 8'h01, 8'h02, tv[7:0]);
      end_of_test();
   end
endmodule
